// ==== rtl/tdm_highway_serial_port.v ====
/*
  TDM highway serial port: register port, bit clock and frame sync generation or
  tracking, timeslot switches, ping-pong holding registers and DMA address generation.
  Assumes a single-request DMA controller that answers each request with one ack pulse.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "tdm_highway_map.vh"

module tdm_highway_serial_port (
  input  wire        clk_sys_in,
  input  wire        reset_in,
  input  wire [7:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out,
  input  wire        highway_bit_clock_in,
  output reg         highway_bit_clock_out,
  output reg         highway_bit_clock_oe_out,
  input  wire        highway_frame_sync_in,
  output reg         highway_frame_sync_out,
  output reg         highway_frame_sync_oe_out,
  input  wire        serial_rx_line_in,
  output reg         serial_tx_line_out,
  output reg         serial_tx_line_oe_out,
  output reg         dma_tx_req_out,
  output reg  [31:0] dma_tx_addr_out,
  input  wire        dma_tx_ack_in,
  input  wire [31:0] dma_tx_data_in,
  output reg         dma_rx_req_out,
  output reg  [31:0] dma_rx_addr_out,
  output reg  [31:0] dma_rx_data_out,
  input  wire        dma_rx_ack_in
);

  function [2:0] sw_match;
    input [4:0]  ch;
    input [31:0] sw;
    integer      k;
    begin
      sw_match = 3'b000;
      for (k = 0; k < 4; k = k + 1)
        if (sw[8*k+7] && sw[8*k +: 5] == ch)
          sw_match = {1'b1, k[1:0]};
    end
  endfunction

  function [7:0] rev8;
    input [7:0] b;
    integer     k;
    begin
      rev8 = 8'h00;
      for (k = 0; k < 8; k = k + 1)
        rev8[k] = b[7-k];
    end
  endfunction

  // Memory bits 31:24 land in byte0 little-endian, byte3 big-endian
  function [31:0] lane_map;
    input [31:0] w;
    input        big;
    begin
      lane_map = big ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction

  function [9:0] wrap_pos;
    input [9:0] b;
    input [7:0] off;
    input [9:0] len;
    begin
      if (b >= {2'b00, off})
        wrap_pos = b - {2'b00, off};
      else
        wrap_pos = b + len - {2'b00, off};
    end
  endfunction

  // {end, half, next pointer}
  function [13:0] ptr_adv;
    input [11:0] p;
    input [11:0] last;
    input        circ;
    begin
      ptr_adv[13] = (p == last);
      ptr_adv[12] = (p == {1'b0, last[11:1]});
      if (p != last)
        ptr_adv[11:0] = p + 12'h001;
      else
        ptr_adv[11:0] = circ ? 12'h000 : p;
    end
  endfunction

  reg  [31:0] ctrl_r;
  reg  [31:0] offs_r;
  reg  [31:0] txsw_a_r;
  reg  [31:0] txsw_b_r;
  reg  [31:0] rxsw_a_r;
  reg  [31:0] rxsw_b_r;
  reg  [11:0] bufw_r;
  reg  [31:0] tx_start_r;
  reg  [31:0] rx_start_r;
  reg  [`TH_EV_W-1:0] stat_r;
  reg  [`TH_EV_W-1:0] ev_nxt;
  reg  [31:0] tx_hold_r [0:1];
  reg  [31:0] rx_hold_r [0:1];
  reg  [1:0]  tx_fresh_r;
  reg  [1:0]  rx_unread_r;
  reg         tx_cur_r;
  reg         rx_cur_r;
  reg  [7:0]  tx_sh_r;
  reg  [7:0]  rx_sh_r;
  reg  [9:0]  fbit_r;
  reg         fs_prev_r;
  reg  [7:0]  div_r;
  reg  [1:0]  bclk_sync_r;
  reg         bclk_d_r;
  reg  [1:0]  fs_sync_r;
  reg  [1:0]  rx_sync_r;
  reg         en_d_r;
  reg  [11:0] tx_ptr_r;
  reg  [11:0] rx_ptr_r;
  reg         tx_done_r;
  reg         rx_done_r;
  reg         rx_pend_r;
  reg  [31:0] rd_mux;
  reg  [13:0] tx_adv;
  reg  [13:0] rx_adv;

  wire        en       = ctrl_r[`TH_EN];
  wire        clk_mst  = ctrl_r[`TH_CLKMST];
  wire        fs_mst   = ctrl_r[`TH_FSMST];
  wire        lsbf     = ctrl_r[`TH_LSBF];
  wire        fs_pol   = ctrl_r[`TH_FSPOL];
  wire        loopb    = ctrl_r[`TH_LOOP];
  wire        big      = ctrl_r[`TH_BIGEND];
  wire [3:0]  fs_w     = ctrl_r[`TH_FSW_MSB:`TH_FSW_LSB];
  wire [7:0]  clk_div  = ctrl_r[`TH_DIV_MSB:`TH_DIV_LSB];
  wire [4:0]  half_m1  = ctrl_r[`TH_HALF_MSB:`TH_HALF_LSB];

  // frame is twice the half length, eight bits a slot
  wire [5:0]  half_slots = {1'b0, half_m1} + 6'h01;
  wire [9:0]  half_bits  = {1'b0, half_slots, 3'b000};
  wire [9:0]  frame_bits = {half_slots, 4'b0000};

  // master divides the system clock, slave follows the synced pin
  wire        mst_tick = en && clk_mst && (div_r == clk_div);
  wire        bit_rise = clk_mst ? (mst_tick && !highway_bit_clock_out)
                                 : (en && bclk_sync_r[1] && !bclk_d_r);
  wire        bit_fall = clk_mst ? (mst_tick && highway_bit_clock_out)
                                 : (en && !bclk_sync_r[1] && bclk_d_r);

  // external sync realigns the bit counter on its leading edge
  wire        fs_act   = fs_pol ? fs_sync_r[1] : !fs_sync_r[1];
  wire        fs_start = !fs_mst && fs_act && !fs_prev_r;
  wire [9:0]  cur_bit  = fs_start ? 10'h000 : fbit_r;
  wire [9:0]  nxt_bit  = (cur_bit == frame_bits - 10'h001) ? 10'h000 : cur_bit + 10'h001;

  // each direction subtracts its own offset from the frame position
  wire [9:0]  tx_pos   = wrap_pos(fbit_r, offs_r[7:0], frame_bits);
  // equal halves for A and B
  wire        tx_half  = (tx_pos >= half_bits);
  wire [9:0]  tx_in    = tx_half ? tx_pos - half_bits : tx_pos;
  wire [9:0]  rx_pos   = wrap_pos(cur_bit, offs_r[15:8], frame_bits);
  wire        rx_half  = (rx_pos >= half_bits);
  wire [9:0]  rx_in    = rx_half ? rx_pos - half_bits : rx_pos;

  // transmit switch match for the current slot
  // channel counter compared with switch entries
  wire [2:0]  tx_m     = sw_match(tx_in[7:3], tx_half ? txsw_b_r : txsw_a_r);
  wire [2:0]  rx_m     = sw_match(rx_in[7:3], rx_half ? rxsw_b_r : rxsw_a_r);

  // byte chosen from the holding register the shifter serves
  wire [31:0] tx_word  = tx_hold_r[tx_half];
  wire [7:0]  tx_raw   = tx_word[8*tx_m[1:0] +: 8];
  // bit order applied between holding and shift register
  wire [7:0]  tx_byte  = lsbf ? rev8(tx_raw) : tx_raw;
  wire [7:0]  rx_raw   = {rx_sh_r[6:0], rx_sync_r[1]};
  wire [7:0]  rx_byte  = lsbf ? rev8(rx_raw) : rx_raw;
  wire        rx_last  = bit_rise && (rx_in == half_bits - 10'h001);
  wire        tx_first = bit_fall && (tx_in == 10'h000);

  wire        hold_wr  = reg_wr_in && (reg_addr_in == `TH_HOLD);
  wire        hold_rd  = reg_rd_in && (reg_addr_in == `TH_HOLD);
  wire        tx_ack   = dma_tx_req_out && dma_tx_ack_in;
  wire        rx_ack   = dma_rx_req_out && dma_rx_ack_in;
  wire        en_rise  = en && !en_d_r;
  // in loopback the write waits until the same word was read
  wire        rx_gate  = !loopb || (rx_ptr_r != tx_ptr_r);
  wire [31:0] rx_base  = loopb ? tx_start_r : rx_start_r;

  always @*
  begin
    tx_adv = ptr_adv(tx_ptr_r, bufw_r, ctrl_r[`TH_CIRC]);
    rx_adv = ptr_adv(rx_ptr_r, bufw_r, ctrl_r[`TH_CIRC]);
    ev_nxt = {`TH_EV_W{1'b0}};
    ev_nxt[`TH_EV_INA] = en && rx_last && !rx_half;
    ev_nxt[`TH_EV_INB] = en && rx_last && rx_half;
    ev_nxt[`TH_EV_ACT] = !clk_mst && (bclk_sync_r[1] != bclk_d_r);
    // overrun on receive, underrun on transmit
    ev_nxt[`TH_EV_ERR] = (rx_last && rx_unread_r[rx_half])
                      || (tx_first && !tx_fresh_r[tx_half]
                          && ((tx_half ? txsw_b_r : txsw_a_r) != 32'h00000000));
    // half and end points of either pointer
    ev_nxt[`TH_EV_HALF] = (tx_ack && tx_adv[12]) || (rx_ack && rx_adv[12]);
    ev_nxt[`TH_EV_END]  = (tx_ack && tx_adv[13]) || (rx_ack && rx_adv[13]);
    ev_nxt[`TH_EV_INC]  = tx_ack || rx_ack;
    case (reg_addr_in)
      `TH_CTRL:    rd_mux = ctrl_r;
      `TH_OFFS:    rd_mux = offs_r;
      `TH_TXSW_A:  rd_mux = txsw_a_r;
      `TH_TXSW_B:  rd_mux = txsw_b_r;
      `TH_RXSW_A:  rd_mux = rxsw_a_r;
      `TH_RXSW_B:  rd_mux = rxsw_b_r;
      `TH_HOLD:    rd_mux = rx_hold_r[!rx_cur_r];
      `TH_BUFW:    rd_mux = {20'h00000, bufw_r};
      `TH_TXSTART: rd_mux = tx_start_r;
      `TH_RXSTART: rd_mux = rx_start_r;
      `TH_STAT:    rd_mux = {23'h000000, rx_done_r, tx_done_r, stat_r};
      `TH_PTR:     rd_mux = {4'h0, rx_ptr_r, 4'h0, tx_ptr_r};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // Register port; status bits clear on write-one, new events win
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctrl_r        <= `TH_CTRL_RST;
      offs_r        <= 32'h00000000;
      txsw_a_r      <= 32'h00000000;
      txsw_b_r      <= 32'h00000000;
      rxsw_a_r      <= 32'h00000000;
      rxsw_b_r      <= 32'h00000000;
      bufw_r        <= `TH_BUFW_RST;
      tx_start_r    <= 32'h00000000;
      rx_start_r    <= 32'h00000000;
      stat_r        <= {`TH_EV_W{1'b0}};
      reg_rdata_out <= 32'h00000000;
    end
    else
    begin
      // writes land at once; software must not change them while enabled
      if (reg_wr_in)
      begin
        case (reg_addr_in)
          `TH_CTRL:    ctrl_r     <= reg_wdata_in;
          `TH_OFFS:    offs_r     <= {16'h0000, reg_wdata_in[15:0]};
          `TH_TXSW_A:  txsw_a_r   <= reg_wdata_in & 32'h9f9f9f9f;
          `TH_TXSW_B:  txsw_b_r   <= reg_wdata_in & 32'h9f9f9f9f;
          `TH_RXSW_A:  rxsw_a_r   <= reg_wdata_in & 32'h9f9f9f9f;
          `TH_RXSW_B:  rxsw_b_r   <= reg_wdata_in & 32'h9f9f9f9f;
          // word count minus one, 16 B to 16 KB
          `TH_BUFW:    bufw_r     <= (reg_wdata_in[11:0] < 12'h003) ? 12'h003
                                                                    : reg_wdata_in[11:0];
          `TH_TXSTART: tx_start_r <= {reg_wdata_in[31:2], 2'b00};
          `TH_RXSTART: rx_start_r <= {reg_wdata_in[31:2], 2'b00};
          default:     ;
        endcase
      end
      if (reg_wr_in && reg_addr_in == `TH_STAT)
        stat_r <= (stat_r & ~reg_wdata_in[`TH_EV_W-1:0]) | ev_nxt;
      else
        stat_r <= stat_r | ev_nxt;
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
    end
  end

  // Pin synchronisers; first stages feed only second stages
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      bclk_sync_r <= `TH_SYNC_RST;
      fs_sync_r   <= `TH_SYNC_RST;
      rx_sync_r   <= `TH_SYNC_RST;
      bclk_d_r    <= 1'b0;
      en_d_r      <= 1'b0;
    end
    else
    begin
      bclk_sync_r <= {bclk_sync_r[0], highway_bit_clock_in};
      fs_sync_r   <= {fs_sync_r[0], highway_frame_sync_in};
      rx_sync_r   <= {rx_sync_r[0], serial_rx_line_in};
      bclk_d_r    <= bclk_sync_r[1];
      en_d_r      <= en;
    end
  end

  // Bit clock, frame sync and serial shifting
  always @(posedge clk_sys_in)
  begin
    if (reset_in || !en)
    begin
      div_r                     <= 8'h00;
      highway_bit_clock_out     <= 1'b0;
      highway_bit_clock_oe_out  <= 1'b0;
      highway_frame_sync_out    <= 1'b0;
      highway_frame_sync_oe_out <= 1'b0;
      serial_tx_line_out        <= 1'b0;
      serial_tx_line_oe_out     <= 1'b0;
      fbit_r                    <= 10'h000;
      fs_prev_r                 <= 1'b0;
      tx_sh_r                   <= 8'h00;
      rx_sh_r                   <= 8'h00;
      tx_cur_r                  <= 1'b0;
      rx_cur_r                  <= 1'b0;
    end
    else
    begin
      div_r                     <= mst_tick ? 8'h00 : div_r + 8'h01;
      highway_bit_clock_oe_out  <= clk_mst;
      highway_frame_sync_oe_out <= fs_mst;
      if (mst_tick)
        highway_bit_clock_out <= !highway_bit_clock_out;
      if (bit_rise)
      begin
        fbit_r    <= nxt_bit;
        fs_prev_r <= fs_act;
        // driven sync active for the programmed bit count
        highway_frame_sync_out <= fs_pol ^ ({6'h00, fs_w} <= nxt_bit);
        rx_sh_r   <= rx_raw;
        rx_cur_r  <= rx_last ? !rx_half : rx_half;
      end
      if (bit_fall)
      begin
        tx_cur_r <= tx_half;
        // line released outside selected, enabled slots
        serial_tx_line_oe_out <= tx_m[2];
        if (tx_in[2:0] == 3'b000)
        begin
          serial_tx_line_out <= tx_byte[7];
          tx_sh_r            <= {tx_byte[6:0], 1'b0};
        end
        else
        begin
          serial_tx_line_out <= tx_sh_r[7];
          tx_sh_r            <= {tx_sh_r[6:0], 1'b0};
        end
      end
    end
  end

  // Holding registers and DMA address generation
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      tx_hold_r[0]    <= 32'h00000000;
      tx_hold_r[1]    <= 32'h00000000;
      rx_hold_r[0]    <= 32'h00000000;
      rx_hold_r[1]    <= 32'h00000000;
      tx_fresh_r      <= 2'b00;
      rx_unread_r     <= 2'b00;
      tx_ptr_r        <= 12'h000;
      rx_ptr_r        <= 12'h000;
      tx_done_r       <= 1'b0;
      rx_done_r       <= 1'b0;
      rx_pend_r       <= 1'b0;
      dma_tx_req_out  <= 1'b0;
      dma_rx_req_out  <= 1'b0;
      dma_tx_addr_out <= 32'h00000000;
      dma_rx_addr_out <= 32'h00000000;
      dma_rx_data_out <= 32'h00000000;
    end
    else
    begin
      // address is start plus four times the word pointer
      dma_tx_addr_out <= tx_start_r + {18'h00000, tx_ptr_r, 2'b00};
      dma_rx_addr_out <= rx_base + {18'h00000, rx_ptr_r, 2'b00};
      // A write in the same cycle as the half start wins over the clear
      if (tx_first)
        tx_fresh_r[tx_half] <= 1'b0;
      // every write goes to the buffer the shifter is not using
      if (tx_ack)
      begin
        // lane order from the endian bit
        tx_hold_r[!tx_cur_r]  <= lane_map(dma_tx_data_in, big);
        tx_fresh_r[!tx_cur_r] <= 1'b1;
      end
      else if (hold_wr)
      begin
        tx_hold_r[!tx_cur_r]  <= reg_wdata_in;
        tx_fresh_r[!tx_cur_r] <= 1'b1;
      end
      // matched byte stored in its field
      if (en && bit_rise && rx_in[2:0] == 3'b111 && rx_m[2])
        rx_hold_r[rx_half][8*rx_m[1:0] +: 8] <= rx_byte;
      // unread flag; a new word wins over a clearing read
      if (hold_rd)
        rx_unread_r[!rx_cur_r] <= 1'b0;
      if (rx_ack)
        rx_unread_r[!rx_cur_r] <= 1'b0;
      if (en && rx_last)
        rx_unread_r[rx_half] <= 1'b1;
      // pointers restart when the port is enabled
      if (en_rise)
      begin
        tx_ptr_r       <= 12'h000;
        rx_ptr_r       <= 12'h000;
        tx_done_r      <= 1'b0;
        rx_done_r      <= 1'b0;
        rx_pend_r      <= 1'b0;
        dma_tx_req_out <= 1'b0;
        dma_rx_req_out <= 1'b0;
      end
      else
      begin
        // advance on acknowledge; circular wraps, one-time stops
        // A and B words alternate because requests follow the halves
        if (tx_ack)
        begin
          tx_ptr_r       <= tx_adv[11:0];
          tx_done_r      <= tx_adv[13] && !ctrl_r[`TH_CIRC];
          dma_tx_req_out <= 1'b0;
        end
        // per-direction DMA enable; otherwise the CPU serves it
        else if (en && rx_last && ctrl_r[`TH_TXDMA] && !tx_done_r)
          dma_tx_req_out <= 1'b1;
        if (rx_ack)
        begin
          rx_ptr_r  <= rx_adv[11:0];
          rx_done_r <= rx_adv[13] && !ctrl_r[`TH_CIRC];
          rx_pend_r <= 1'b0;
        end
        else if (en && rx_last && ctrl_r[`TH_RXDMA] && !rx_done_r)
        begin
          rx_pend_r       <= 1'b1;
          dma_rx_data_out <= lane_map(rx_hold_r[rx_half], big);
        end
        dma_rx_req_out <= rx_pend_r && rx_gate && !rx_ack;
      end
    end
  end

endmodule

// ==== rtl/tdm_highway_map.vh ====
/*
  Register offsets, field positions and reset values for the TDM highway serial port.
  Assumes a byte-addressed register port with one aligned 32-bit word per register.
*/
// Summary of operation
// - Two 32-bit transmit holding registers feed one shifter
// - Per-byte bit order selectable, MSB or LSB first
// - Frame slots split evenly between buffers A and B
// - One holding location, steered to the free buffer
// - Transmit switch picks four channels per buffer
// - Transmit line released outside selected transmit slots
// - Each of eight channels has its own enable
// - Independent receive switch fills receive holding A/B
// - Word-ready event per buffer, also means transmit-free
// - Bit clock driven by divider or tracked from pin
// - Frame sync driven with width/polarity, or tracked
// - Separate receive and transmit bit offsets after sync
// - Channel counters compared to switch, byte moved on match
// - DMA buffer 16 B to 16 KB, separate start addresses
// - Loopback: receive written after transmit read, same word
// - Address advances per acknowledge; wrap or stop at end
// - Memory alternates buffer A and B words per sample
// - Byte lanes swapped between little and big endian
// - Events at half-buffer and end-of-buffer points
// - Independent DMA enables; otherwise CPU accesses holding register
// - Event per pointer increment; 12-bit pointer readable
// - Error event when software or DMA falls behind
// - Up to 64 slots per frame, even, eight bits each
`ifndef TDM_HIGHWAY_MAP_VH
`define TDM_HIGHWAY_MAP_VH

`define TH_CTRL      8'h00
`define TH_OFFS      8'h04
`define TH_TXSW_A    8'h08
`define TH_TXSW_B    8'h0c
`define TH_RXSW_A    8'h10
`define TH_RXSW_B    8'h14
`define TH_HOLD      8'h18
`define TH_BUFW      8'h1c
`define TH_TXSTART   8'h20
`define TH_RXSTART   8'h24
`define TH_STAT      8'h28
`define TH_PTR       8'h2c

`define TH_EN        0
`define TH_CLKMST    1
`define TH_FSMST     2
`define TH_LSBF      3
`define TH_FSPOL     4
`define TH_TXDMA     5
`define TH_RXDMA     6
`define TH_CIRC      7
`define TH_LOOP      8
`define TH_BIGEND    9
`define TH_FSW_LSB   10
`define TH_FSW_MSB   13
`define TH_DIV_LSB   14
`define TH_DIV_MSB   21
`define TH_HALF_LSB  22
`define TH_HALF_MSB  26

`define TH_EV_HALF   0
`define TH_EV_END    1
`define TH_EV_INC    2
`define TH_EV_INA    3
`define TH_EV_INB    4
`define TH_EV_ACT    5
`define TH_EV_ERR    6
`define TH_EV_W      7

`define TH_CTRL_RST  32'h00000000
`define TH_BUFW_RST  12'h003
`define TH_SYNC_RST  2'b00

`endif

// ==== testbench/tdm_port_sva.sv ====
/*
  Port assertions for the TDM highway serial port, bound to its top module.
  Assumes control words change only through the register port.
*/
`timescale 1ns/1ps
`include "tdm_highway_map.vh"
module tdm_port_sva (
  input logic        clk_sys_in,
  input logic        reset_in,
  input logic [7:0]  reg_addr_in,
  input logic [31:0] reg_wdata_in,
  input logic        reg_wr_in,
  input logic        highway_bit_clock_out,
  input logic        highway_bit_clock_oe_out,
  input logic        highway_frame_sync_oe_out,
  input logic        serial_tx_line_oe_out,
  input logic        dma_tx_req_out,
  input logic [31:0] dma_tx_addr_out,
  input logic        dma_tx_ack_in,
  input logic        dma_rx_req_out,
  input logic [31:0] dma_rx_addr_out
);
  logic [31:0] ctrl_r;
  logic [31:0] txs_r;
  logic [11:0] bufw_r;
  logic [1:0]  dis_r;
  logic        bc_r;
  logic [8:0]  cnt_r;
  wire         tog = highway_bit_clock_out != bc_r;
  // Shadows of the control words, so the checks know the programmed figures
  always @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ctrl_r <= 32'h0;
      txs_r  <= 32'h0;
      bufw_r <= 12'h003;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `TH_CTRL) ctrl_r <= reg_wdata_in;
      if (reg_addr_in == `TH_TXSTART) txs_r <= {reg_wdata_in[31:2], 2'b00};
      if (reg_addr_in == `TH_BUFW) bufw_r <= reg_wdata_in[11:0];
    end
    dis_r <= (reset_in || ctrl_r[0]) ? 2'd0 : (dis_r == 2'd3 ? dis_r : dis_r + 2'd1);
    bc_r  <= highway_bit_clock_out;
    // Count only from a seen edge, the first half after enabling may be short
    cnt_r <= (reset_in || !highway_bit_clock_oe_out) ? 9'h0 :
             (tog ? 9'h1 : (cnt_r != 9'h0 ? cnt_r + 9'h1 : cnt_r));
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  AST_BCLK_HALF: assert property (
    ctrl_r[0] && highway_bit_clock_oe_out && tog && cnt_r != 9'h0
    |-> cnt_r == {1'b0, ctrl_r[21:14]} + 9'h1) else $error("bit clock half period wrong");
  AST_IDLE_RELEASE: assert property (
    dis_r == 2'd3 |-> !serial_tx_line_oe_out && !highway_frame_sync_oe_out
    && !highway_bit_clock_oe_out && !highway_bit_clock_out) else $error("pins driven while off");
  AST_TXREQ_DROP: assert property (
    dma_tx_req_out && dma_tx_ack_in |=> !dma_tx_req_out) else $error("tx req kept after ack");
  AST_RXREQ_DROP: assert property (
    dma_rx_req_out && $past(dma_rx_req_out) |-> ##[0:300] !dma_rx_req_out)
    else $error("rx req never served");
  AST_TXREQ_GATE: assert property (
    $rose(dma_tx_req_out) |-> ctrl_r[0] && ctrl_r[5]) else $error("tx req without dma enable");
  AST_RXREQ_GATE: assert property (
    $rose(dma_rx_req_out) |-> ctrl_r[0] && ctrl_r[6]) else $error("rx req without dma enable");
  AST_TXADDR_RANGE: assert property (
    dma_tx_req_out |-> dma_tx_addr_out[1:0] == 2'b00
    && (dma_tx_addr_out - txs_r) < ({18'h0, bufw_r, 2'b00} + 32'h4))
    else $error("tx address outside buffer");
  AST_TXADDR_HOLD: assert property (
    dma_tx_req_out && !dma_tx_ack_in |=> $stable(dma_tx_addr_out)) else $error("tx address moved");
  AST_RXADDR_ALIGN: assert property (
    dma_rx_req_out |-> dma_rx_addr_out[1:0] == 2'b00) else $error("rx address unaligned");
endmodule
bind tdm_highway_serial_port tdm_port_sva u_tdm_port_sva (
  .clk_sys_in(clk_sys_in),
  .reset_in(reset_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .highway_bit_clock_out(highway_bit_clock_out),
  .highway_bit_clock_oe_out(highway_bit_clock_oe_out),
  .highway_frame_sync_oe_out(highway_frame_sync_oe_out),
  .serial_tx_line_oe_out(serial_tx_line_oe_out),
  .dma_tx_req_out(dma_tx_req_out),
  .dma_tx_addr_out(dma_tx_addr_out),
  .dma_tx_ack_in(dma_tx_ack_in),
  .dma_rx_req_out(dma_rx_req_out),
  .dma_rx_addr_out(dma_rx_addr_out)
);

// ==== testbench/tdm_echo_peer.sv ====
/*
  Highway peer that returns every transmitted bit on the receive line.
  Assumes the port drives the bit clock; no pull resistor on the line.
*/
`timescale 1ns/1ps
module tdm_echo_peer (
  input  logic clk_sys_in,
  input  logic tx_line_in,
  input  logic tx_oe_in,
  output logic rx_line_out
);
  logic last_r = 1'b0;
  always @(posedge clk_sys_in)
    if (tx_oe_in) last_r <= tx_line_in;
  // released line shows no stale level
  assign rx_line_out = tx_oe_in ? tx_line_in : ~last_r;
endmodule

// ==== testbench/tdm_highway_serial_port_bench.sv ====
/*
  Self-checking bench for the TDM highway serial port with an echo peer.
  Assumes a prompt DMA responder; two slots of four selected in each half.
*/
`timescale 1ns/1ps
`include "tdm_highway_map.vh"
module tdm_highway_serial_port_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        txack = 1'b0;
  logic        rxack = 1'b0;
  logic [31:0] mem = 32'h5a1e7766;
  logic [31:0] rdata, txaddr, rxaddr, rxdata, rxlast;
  logic        bclk, bclk_oe, fs, fs_oe, tx, tx_oe, rx, txreq, rxreq;
  logic [7:0]  cap = 8'h00;
  logic [7:0]  ocnt = 8'h00;
  logic [7:0]  frm = 8'h00;
  logic [7:0]  ntx = 8'h00;
  logic [7:0]  nrx = 8'h00;
  logic        bprev = 1'b0;
  logic        fprev = 1'b0;
  int          num_errors = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  tdm_highway_serial_port u_tdm_highway_serial_port (
    .clk_sys_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .highway_bit_clock_in(1'b0), .highway_bit_clock_out(bclk),
    .highway_bit_clock_oe_out(bclk_oe), .highway_frame_sync_in(1'b0),
    .highway_frame_sync_out(fs), .highway_frame_sync_oe_out(fs_oe),
    .serial_rx_line_in(rx), .serial_tx_line_out(tx), .serial_tx_line_oe_out(tx_oe),
    .dma_tx_req_out(txreq), .dma_tx_addr_out(txaddr), .dma_tx_ack_in(txack),
    .dma_tx_data_in(mem), .dma_rx_req_out(rxreq), .dma_rx_addr_out(rxaddr),
    .dma_rx_data_out(rxdata), .dma_rx_ack_in(rxack));
  tdm_echo_peer u_tdm_echo_peer (
    .clk_sys_in(clk), .tx_line_in(tx), .tx_oe_in(tx_oe), .rx_line_out(rx));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Wire watch: last driven byte and driven bits per frame
  always @(posedge clk)
  begin
    bprev <= bclk;
    fprev <= fs;
    if (bclk && !bprev && tx_oe) cap <= {cap[6:0], tx};
    ocnt <= (fs && !fprev ? 8'h00 : ocnt) + {7'h0, bclk && !bprev && tx_oe};
    if (fs && !fprev) frm <= ocnt;
  end
  // DMA responder: one ack per request, addresses judged as taken
  always @(posedge clk)
  begin
    txack <= txreq && !txack;
    rxack <= rxreq && !rxack;
    if (txreq && txack)
    begin
      check(txaddr, 32'h10000000 + {28'h0, ntx[1:0], 2'b00});
      ntx <= ntx + 8'h01;
    end
    if (rxreq && rxack)
    begin
      check(rxaddr, 32'h20000000 + {28'h0, nrx[1:0], 2'b00});
      rxlast <= rxdata;
      nrx <= nrx + 8'h01;
    end
  end
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task poll(output logic [31:0] s);
    s = 32'h0;
    for (int i = 0; i < 400 && s[4:3] == 2'b00; i++)
      rd_reg(`TH_STAT, s);
    check({31'h0, s[4:3] != 2'b00}, 32'h1);
    wr_reg(`TH_STAT, s);
  endtask
  // Eight-slot frame, bit time of eight cycles, channels 1 and 3 of each half
  task cfg(input logic [31:0] x);
    ntx = 8'h00;
    nrx = 8'h00;
    wr_reg(`TH_OFFS, 32'h0);
    wr_reg(`TH_STAT, 32'hffffffff);
    for (int i = 0; i < 4; i++)
      wr_reg(`TH_TXSW_A + 8'(i * 4), 32'h00028381);
    wr_reg(`TH_CTRL, 32'h00c0c417 | x);
  endtask
  task t_regs;
    logic [31:0] v;
    rd_reg(`TH_CTRL, v);
    check(v, 32'h0);
    rd_reg(`TH_BUFW, v);
    check(v, 32'h3);
    rd_reg(8'h30, v);
    check(v, 32'h0);
    wr_reg(`TH_TXSTART, 32'h10000003);
    wr_reg(`TH_RXSTART, 32'h20000000);
    wr_reg(`TH_BUFW, 32'hfff);
    rd_reg(`TH_TXSTART, v);
    check(v, 32'h10000000);
    rd_reg(`TH_BUFW, v);
    check(v, 32'hfff);
    wr_reg(`TH_BUFW, 32'h3);
  endtask
  task t_cpu(input logic l);
    logic [31:0] s;
    logic [31:0] v;
    cfg({28'h0, l, 3'h0});
    for (int k = 0; k < 16; k++)
    begin
      poll(s);
      rd_reg(`TH_HOLD, v);
      wr_reg(`TH_HOLD, 32'h77661e5a);
    end
    check({16'h0, v[15:0]}, 32'h1e5a);
    check({24'h0, cap}, l ? 32'h78 : 32'h1e);
    check({24'h0, frm}, 32'h20);
    // Left unserviced on purpose for two frames
    repeat (1100) @(posedge clk);
    rd_reg(`TH_STAT, s);
    check({31'h0, s[6]}, 32'h1);
    wr_reg(`TH_CTRL, 32'h0);
  endtask
  task t_dma(input logic b);
    logic [31:0] s;
    cfg({22'h0, b, 9'h0e0});
    for (int k = 0; k < 12; k++)
      poll(s);
    check({24'h0, cap}, b ? 32'h77 : 32'h1e);
    rd_reg(`TH_PTR, s);
    check(s & 32'h0fff0fff, {14'h0, nrx[1:0], 14'h0, ntx[1:0]});
    repeat (1100) @(posedge clk);
    rd_reg(`TH_STAT, s);
    check({29'h0, s[2:0]}, 32'h7);
    wr_reg(`TH_CTRL, 32'h0);
    check(b ? {16'h0, rxlast[15:0]} : {rxlast[31:16], 16'h0},
          b ? 32'h00007766 : 32'h5a1e0000);
  endtask
  task end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_cpu(1'b0);
    t_cpu(1'b1);
    t_dma(1'b0);
    t_dma(1'b1);
    end_sim;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_sim;
  end
endmodule
